// file: rtl/keying_pkg.sv
// Constants shared by the repeater keying, timer and scan logic
package keying_pkg;

    // Clock and base tick
    localparam int CLK_FREQ_HZ = 25_000_000;
    localparam int TICK_PERIOD_MS = 1;
    localparam int MS_TICK_CYCLES = CLK_FREQ_HZ / 1000 * TICK_PERIOD_MS;

    // Channels and keying sources
    localparam int NUM_CH = 4;
    localparam int CH_W = 2;
    localparam int NUM_SRC = 3;
    localparam int SRC_LOCAL = 0;
    localparam int SRC_REMOTE = 1;
    localparam int SRC_REPEAT = 2;

    // Pins that pass the two-stage synchroniser
    localparam int NUM_PINS = 4;
    localparam int PIN_LOCAL = 0;
    localparam int PIN_REMOTE = 1;
    localparam int PIN_SQUELCH = 2;
    localparam int PIN_CODE = 3;

    // Scan dwell per channel, counted in ms ticks
    localparam int SCAN_DWELL_MS = 80;
    localparam int DWELL_W = 7;
    localparam logic [DWELL_W-1:0] DWELL_LAST = DWELL_W'(SCAN_DWELL_MS - 1);

    // Keyup limit: 0..600 s in 1 s steps, shipped at 3 minutes
    localparam int LIMIT_W = 10;
    localparam int KEYUP_LIMIT_MAX_S = 600;
    localparam int KEYUP_STEP_MS = 1000;
    localparam logic [LIMIT_W-1:0] KEYUP_LIMIT_DEFAULT_S = 10'h0B4;

    // Dropout hold: 0..10 s in 100 ms steps, shipped at 3 s
    localparam int HOLD_W = 7;
    localparam int HOLD_MAX_STEPS = 100;
    localparam int HOLD_STEP_MS = 100;
    localparam logic [HOLD_W-1:0] HOLD_DEFAULT_STEPS = 7'h1E;

    // Millisecond counters for the timers
    localparam int MS_CNT_W = 20;
    localparam logic [MS_CNT_W-1:0] MS_CNT_RESET = 20'h0_0000;

    // Reset values
    localparam logic [CH_W-1:0] CH_RESET = 2'h0;
    localparam logic [DWELL_W-1:0] DWELL_RESET = 7'h00;

    typedef enum logic {
        SCAN_STEP,
        SCAN_LOCK
    } scan_state_t;

endpackage

// file: rtl/ms_tick_gen.sv
// Free-running divider that emits a one-cycle tick every TICK_CYCLES clocks
`timescale 1ns/1ps
module ms_tick_gen #(
    parameter int TICK_CYCLES = 25000
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Tick
    output logic o_tick
);
    localparam int CNT_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TICK_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;

    logic [CNT_W-1:0] cnt_q;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q <= CNT_ZERO;
            o_tick <= 1'b0;
        end else if (cnt_q == CNT_LAST) begin
            cnt_q <= CNT_ZERO;
            o_tick <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 1'b1;
            o_tick <= 1'b0;
        end
    end

endmodule // ms_tick_gen

// file: rtl/repeater_keying_timers_scan.sv
// Transmitter keying, keyup limit timers, dropout hold timer and receive scan
`timescale 1ns/1ps

// What this block does
// - Step through scan channels while all quiet
// - Stop scanning, stay while message lasts
// - Dwell 80 ms on each scanned channel
// - Unsquelched receiver locks scan onto channel
// - Keyup limit zero to 600 s, 1 s
// - Shipped keyup limit is three minutes
// - Separate limit timers per source, all cleared together on any release
// - Timing starts on keying; repeat needs code
// - Timer clears on unkey or any release
// - Limit reached drops amplifier and antenna outputs
// - Timed-out repeat blocked until all released
// - Timed-out repeat does not block others
// - Hold time zero to 10 s, 100 ms
// - Shipped hold time is three seconds
// - Hold starts at repeat end, stays keyed
// - New transmission during hold keeps carrier up
// - Hold applies to repeat transmissions only
// - Per-channel enables for both timers
// - Per-channel time values, active channel applied
// - Per-channel repeat enable gates repeat keying
module repeater_keying_timers_scan #(
    parameter int MS_TICK_CYCLES = keying_pkg::MS_TICK_CYCLES
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Push-to-talk and receiver pins, asynchronous
    input wire logic i_local_ptt,
    input wire logic i_remote_ptt,
    input wire logic i_squelch_open,
    input wire logic i_subaudible_squelch_code,
    // System options from the personality store
    input wire logic i_personality_valid,
    input wire logic i_scan_enable,
    input wire logic i_code_fitted,
    input wire logic [keying_pkg::CH_W-1:0] i_home_channel,
    // Per-channel options from the personality store
    input wire logic [keying_pkg::NUM_CH-1:0] i_scan_member,
    input wire logic [keying_pkg::NUM_CH-1:0] i_repeat_en,
    input wire logic [keying_pkg::NUM_CH-1:0] i_keyup_timer_en,
    input wire logic [keying_pkg::NUM_CH-1:0] i_hold_timer_en,
    input wire logic [keying_pkg::NUM_CH*keying_pkg::LIMIT_W-1:0] i_local_limit_s,
    input wire logic [keying_pkg::NUM_CH*keying_pkg::LIMIT_W-1:0] i_remote_limit_s,
    input wire logic [keying_pkg::NUM_CH*keying_pkg::LIMIT_W-1:0] i_repeat_limit_s,
    input wire logic [keying_pkg::NUM_CH*keying_pkg::HOLD_W-1:0] i_hold_steps,
    // Transmitter and receiver controls
    output logic o_amplifier_key_output,
    output logic o_antenna_switch_output,
    output logic [keying_pkg::CH_W-1:0] o_channel_sel,
    // Status
    output logic o_scan_locked,
    output logic o_holding,
    output logic [keying_pkg::NUM_SRC-1:0] o_timed_out
);

    logic ms_tick;
    logic [keying_pkg::NUM_PINS-1:0] pin_meta_q;
    logic [keying_pkg::NUM_PINS-1:0] pin_sync_q;
    logic [keying_pkg::CH_W-1:0] ch_q;
    logic [keying_pkg::DWELL_W-1:0] dwell_q;
    keying_pkg::scan_state_t scan_state_q;
    logic [keying_pkg::NUM_SRC-1:0] raw_req;
    logic [keying_pkg::NUM_SRC-1:0] raw_req_q;
    logic [keying_pkg::NUM_SRC-1:0] req_eff;
    logic [keying_pkg::NUM_SRC-1:0] req_eff_q;
    logic [keying_pkg::NUM_SRC-1:0] timeout_set;
    logic [keying_pkg::NUM_SRC-1:0] timed_out_q;
    logic [keying_pkg::MS_CNT_W-1:0] cnt_q [keying_pkg::NUM_SRC];
    logic [keying_pkg::MS_CNT_W-1:0] limit_ms [keying_pkg::NUM_SRC];
    logic [keying_pkg::LIMIT_W-1:0] limit_s [keying_pkg::NUM_SRC];
    logic [keying_pkg::MS_CNT_W-1:0] hold_cnt_q;
    logic [keying_pkg::MS_CNT_W-1:0] hold_ms;
    logic [keying_pkg::HOLD_W-1:0] hold_steps;
    logic holding_q;
    logic squelch;
    logic code_ok;
    logic any_release;
    logic all_released;
    logic key_next;
    logic member_cur;
    logic dwell_end;
    logic keyup_en_cur;
    logic hold_en_cur;
    logic repeat_en_cur;
    logic hold_start;

    ms_tick_gen #(
        .TICK_CYCLES(MS_TICK_CYCLES)
    ) u_ms_tick (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .o_tick(ms_tick)
    );

    // Two-stage synchroniser for every pin input
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_meta_q <= '0;
            pin_sync_q <= '0;
        end else begin
            pin_meta_q <= {i_subaudible_squelch_code, i_squelch_open, i_remote_ptt, i_local_ptt};
            pin_sync_q <= pin_meta_q;
        end
    end

    assign squelch = pin_sync_q[keying_pkg::PIN_SQUELCH];
    assign code_ok = !i_code_fitted || pin_sync_q[keying_pkg::PIN_CODE];

    // Options of the active channel
    assign member_cur = i_scan_member[ch_q];
    assign repeat_en_cur = i_personality_valid ? i_repeat_en[ch_q] : 1'b1;
    assign keyup_en_cur = i_personality_valid ? i_keyup_timer_en[ch_q] : 1'b1;
    assign hold_en_cur = i_personality_valid ? i_hold_timer_en[ch_q] : 1'b1;

    // Per-channel values, or the shipped defaults without a personality
    always_comb begin
        if (i_personality_valid) begin
            limit_s[keying_pkg::SRC_LOCAL] =
                i_local_limit_s[ch_q*keying_pkg::LIMIT_W +: keying_pkg::LIMIT_W];
            limit_s[keying_pkg::SRC_REMOTE] =
                i_remote_limit_s[ch_q*keying_pkg::LIMIT_W +: keying_pkg::LIMIT_W];
            limit_s[keying_pkg::SRC_REPEAT] =
                i_repeat_limit_s[ch_q*keying_pkg::LIMIT_W +: keying_pkg::LIMIT_W];
            hold_steps = i_hold_steps[ch_q*keying_pkg::HOLD_W +: keying_pkg::HOLD_W];
        end else begin
            limit_s[keying_pkg::SRC_LOCAL] = keying_pkg::KEYUP_LIMIT_DEFAULT_S;
            limit_s[keying_pkg::SRC_REMOTE] = keying_pkg::KEYUP_LIMIT_DEFAULT_S;
            limit_s[keying_pkg::SRC_REPEAT] = keying_pkg::KEYUP_LIMIT_DEFAULT_S;
            hold_steps = keying_pkg::HOLD_DEFAULT_STEPS;
        end
    end

    // Values above the allowed range are clamped to the maximum
    always_comb begin
        if (hold_steps > keying_pkg::HOLD_W'(keying_pkg::HOLD_MAX_STEPS)) begin
            hold_ms = keying_pkg::MS_CNT_W'(keying_pkg::HOLD_MAX_STEPS * keying_pkg::HOLD_STEP_MS);
        end else begin
            hold_ms = keying_pkg::MS_CNT_W'(hold_steps) *
                keying_pkg::MS_CNT_W'(keying_pkg::HOLD_STEP_MS);
        end
    end

    // Receive scan
    assign dwell_end = ms_tick && (dwell_q == keying_pkg::DWELL_LAST);

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            scan_state_q <= keying_pkg::SCAN_STEP;
            ch_q <= keying_pkg::CH_RESET;
            dwell_q <= keying_pkg::DWELL_RESET;
        end else if (!i_scan_enable) begin
            scan_state_q <= keying_pkg::SCAN_STEP;
            ch_q <= i_home_channel;
            dwell_q <= keying_pkg::DWELL_RESET;
        end else begin
            unique case (scan_state_q)
                keying_pkg::SCAN_STEP: begin
                    if (squelch && member_cur) begin
                        scan_state_q <= keying_pkg::SCAN_LOCK;
                        dwell_q <= keying_pkg::DWELL_RESET;
                    end else if (o_amplifier_key_output) begin
                        dwell_q <= keying_pkg::DWELL_RESET;
                    end else if (!member_cur || dwell_end) begin
                        ch_q <= ch_q + 1'b1;
                        dwell_q <= keying_pkg::DWELL_RESET;
                    end else if (ms_tick) begin
                        dwell_q <= dwell_q + 1'b1;
                    end
                end
                keying_pkg::SCAN_LOCK: begin
                    // Stay put while the message lasts or the transmitter is keyed by any source or hold
                    if (!squelch && !o_amplifier_key_output) begin
                        scan_state_q <= keying_pkg::SCAN_STEP;
                    end
                end
            endcase
        end
    end

    // Keying requests
    assign raw_req[keying_pkg::SRC_LOCAL] = pin_sync_q[keying_pkg::PIN_LOCAL];
    assign raw_req[keying_pkg::SRC_REMOTE] = pin_sync_q[keying_pkg::PIN_REMOTE];
    assign raw_req[keying_pkg::SRC_REPEAT] = squelch && code_ok && repeat_en_cur;
    assign req_eff = raw_req & ~timed_out_q;
    assign any_release = |(raw_req_q & ~raw_req);
    assign all_released = ~|raw_req;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            raw_req_q <= '0;
            req_eff_q <= '0;
        end else begin
            raw_req_q <= raw_req;
            req_eff_q <= req_eff;
        end
    end

    // One keyup limit timer per source
    genvar s;
    generate
        for (s = 0; s < keying_pkg::NUM_SRC; s++) begin : g_keyup
            assign limit_ms[s] = (limit_s[s] > keying_pkg::LIMIT_W'(keying_pkg::KEYUP_LIMIT_MAX_S))
                ? keying_pkg::MS_CNT_W'(keying_pkg::KEYUP_LIMIT_MAX_S * keying_pkg::KEYUP_STEP_MS)
                : keying_pkg::MS_CNT_W'(limit_s[s]) *
                  keying_pkg::MS_CNT_W'(keying_pkg::KEYUP_STEP_MS);
            assign timeout_set[s] = keyup_en_cur && req_eff[s] && (cnt_q[s] >= limit_ms[s]);

            always_ff @(posedge i_core_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    cnt_q[s] <= keying_pkg::MS_CNT_RESET;
                end else if (!req_eff[s] || any_release) begin
                    cnt_q[s] <= keying_pkg::MS_CNT_RESET;
                end else if (ms_tick && cnt_q[s] < limit_ms[s]) begin
                    cnt_q[s] <= cnt_q[s] + 1'b1;
                end
            end

            // Repeat stays blocked until every source lets go; set wins over clear
            always_ff @(posedge i_core_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    timed_out_q[s] <= 1'b0;
                end else if (timeout_set[s]) begin
                    timed_out_q[s] <= 1'b1;
                end else if (s == keying_pkg::SRC_REPEAT ? all_released : !raw_req[s]) begin
                    timed_out_q[s] <= 1'b0;
                end
            end
        end
    endgenerate

    // Dropout hold after a repeat ends on its own
    assign hold_start = req_eff_q[keying_pkg::SRC_REPEAT] && !raw_req[keying_pkg::SRC_REPEAT]
        && hold_en_cur && (hold_ms != keying_pkg::MS_CNT_RESET);

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            holding_q <= 1'b0;
            hold_cnt_q <= keying_pkg::MS_CNT_RESET;
        end else if (hold_start) begin
            holding_q <= 1'b1;
            hold_cnt_q <= keying_pkg::MS_CNT_RESET;
        end else if (|req_eff) begin
            holding_q <= 1'b0;
            hold_cnt_q <= keying_pkg::MS_CNT_RESET;
        end else if (holding_q && (!hold_en_cur || hold_cnt_q >= hold_ms)) begin
            holding_q <= 1'b0;
        end else if (holding_q && ms_tick) begin
            hold_cnt_q <= hold_cnt_q + 1'b1;
        end
    end

    // Transmitter outputs
    assign key_next = (|req_eff) || holding_q || hold_start;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_amplifier_key_output <= 1'b0;
            o_antenna_switch_output <= 1'b0;
        end else begin
            o_amplifier_key_output <= key_next;
            o_antenna_switch_output <= key_next;
        end
    end

    // Status outputs
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_channel_sel <= keying_pkg::CH_RESET;
            o_scan_locked <= 1'b0;
            o_holding <= 1'b0;
            o_timed_out <= '0;
        end else begin
            o_channel_sel <= ch_q;
            o_scan_locked <= (scan_state_q == keying_pkg::SCAN_LOCK);
            o_holding <= holding_q;
            o_timed_out <= timed_out_q;
        end
    end

    property p_lock_holds_channel;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_scan_enable && scan_state_q == keying_pkg::SCAN_LOCK && squelch) |=> $stable(ch_q);
    endproperty
    a_lock_holds_channel: assert property (p_lock_holds_channel)
        else $error("channel moved while locked on a signal");

    property p_unsquelch_locks;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_scan_enable && $stable(i_scan_enable) && scan_state_q == keying_pkg::SCAN_STEP
            && squelch && member_cur) |=> (scan_state_q == keying_pkg::SCAN_LOCK);
    endproperty
    a_unsquelch_locks: assert property (p_unsquelch_locks)
        else $error("unsquelched scan channel not locked");

    property p_step_only_at_dwell_end;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        ($past(i_scan_enable) && i_scan_enable && $changed(ch_q)) |->
            $past(!member_cur || dwell_q == keying_pkg::DWELL_LAST);
    endproperty
    a_step_only_at_dwell_end: assert property (p_step_only_at_dwell_end)
        else $error("scan stepped before the dwell ended");

    property p_idle_dekeys;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (!(|req_eff) && !holding_q && !hold_start) |=> !o_amplifier_key_output
            && !o_antenna_switch_output;
    endproperty
    a_idle_dekeys: assert property (p_idle_dekeys)
        else $error("transmitter keyed with no request and no hold");

    property p_repeat_lockout;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (timed_out_q[keying_pkg::SRC_REPEAT] && !all_released) |=>
            timed_out_q[keying_pkg::SRC_REPEAT];
    endproperty
    a_repeat_lockout: assert property (p_repeat_lockout)
        else $error("repeat lockout cleared while a source still requests");

    property p_repeat_blocked;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        timed_out_q[keying_pkg::SRC_REPEAT] |-> !req_eff[keying_pkg::SRC_REPEAT];
    endproperty
    a_repeat_blocked: assert property (p_repeat_blocked)
        else $error("repeat keyed while locked out");

    property p_others_not_blocked;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (timed_out_q[keying_pkg::SRC_REPEAT] && raw_req[keying_pkg::SRC_REMOTE]
            && !timed_out_q[keying_pkg::SRC_REMOTE]) |=> o_amplifier_key_output;
    endproperty
    a_others_not_blocked: assert property (p_others_not_blocked)
        else $error("remote keying blocked by repeat timeout");

    property p_hold_keeps_keyed;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        hold_start |=> (o_amplifier_key_output && o_antenna_switch_output && holding_q);
    endproperty
    a_hold_keeps_keyed: assert property (p_hold_keeps_keyed)
        else $error("carrier dropped when hold started");

    property p_repeat_disabled;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        !repeat_en_cur |-> !req_eff[keying_pkg::SRC_REPEAT];
    endproperty
    a_repeat_disabled: assert property (p_repeat_disabled)
        else $error("repeat keyed on a channel with repeat disabled");

    property p_disabled_no_timeout;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        !keyup_en_cur |-> !(|timeout_set);
    endproperty
    a_disabled_no_timeout: assert property (p_disabled_no_timeout)
        else $error("disabled keyup timer timed out");

endmodule // repeater_keying_timers_scan

// file: verification/radio_side_model.sv
// Radio-side model: push-to-talk sources, squelch detector and tone decoder
`timescale 1ns/1ps
module radio_side_model (
    // Clock
    input wire logic i_core_clk,
    // Commanded levels {code, squelch, remote, local} and answer lag in cycles
    input wire logic [3:0] i_cmd,
    input wire logic [1:0] i_lag,
    // Pins towards the shelf
    output logic o_local_ptt,
    output logic o_remote_ptt,
    output logic o_squelch_open,
    output logic o_code_ok
);
    logic [3:0] stage_q [4];

    initial begin
        for (int i = 0; i < 4; i++) begin
            stage_q[i] = 4'h0;
        end
    end

    always @(posedge i_core_clk) begin
        stage_q[0] <= i_cmd;
        for (int i = 1; i < 4; i++) begin
            stage_q[i] <= stage_q[i-1];
        end
    end

    // Slow sources answer a few cycles late; levels then stand until changed
    assign o_local_ptt = stage_q[i_lag][0];
    assign o_remote_ptt = stage_q[i_lag][1];
    assign o_squelch_open = stage_q[i_lag][2];
    assign o_code_ok = stage_q[i_lag][3];
endmodule // radio_side_model

// file: verification/tb_top.sv
// Self-checking bench for the keying, timer and scan block
`timescale 1ns/1ps
module tb_top;
    localparam int MS = 10;
    localparam int CEIL = 90000;
    localparam int TOL = 2 * MS + 6;
    logic i_core_clk, i_rst_n, pv, scan_en, code_fit;
    logic [3:0] cmd, member, rep_en, ku_en, hold_en;
    logic [1:0] lag, home, chsel;
    logic local_pin, remote_pin, sq_pin, code_pin, amp, ant, locked, holding;
    logic [39:0] lim_l, lim_r, lim_p;
    logic [27:0] hold;
    logic [2:0] tmo;
    logic [5:0] obs;
    logic [1:0] prev;
    int bad_count, n_tests, cyc, n, ch;
    int exp_q[$];

    assign obs = {holding, locked, tmo, amp};

    radio_side_model u_radio (.i_core_clk(i_core_clk), .i_cmd(cmd), .i_lag(lag),
        .o_local_ptt(local_pin), .o_remote_ptt(remote_pin), .o_squelch_open(sq_pin),
        .o_code_ok(code_pin));

    repeater_keying_timers_scan #(.MS_TICK_CYCLES(MS)) u_dut (
        .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_local_ptt(local_pin),
        .i_remote_ptt(remote_pin), .i_squelch_open(sq_pin),
        .i_subaudible_squelch_code(code_pin), .i_personality_valid(pv),
        .i_scan_enable(scan_en), .i_code_fitted(code_fit), .i_home_channel(home),
        .i_scan_member(member), .i_repeat_en(rep_en), .i_keyup_timer_en(ku_en),
        .i_hold_timer_en(hold_en), .i_local_limit_s(lim_l), .i_remote_limit_s(lim_r),
        .i_repeat_limit_s(lim_p), .i_hold_steps(hold), .o_amplifier_key_output(amp),
        .o_antenna_switch_output(ant), .o_channel_sel(chsel), .o_scan_locked(locked),
        .o_holding(holding), .o_timed_out(tmo));

    task automatic final_report();
        $display("checks=%0d mismatches=%0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Cycle counts carry tick phase and pin lag, hence the tolerance
    task automatic chk_near(input int got, input int exp, input int tol);
        n_tests++;
        if (got < exp - tol || got > exp + tol) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wait_bit(input int idx, input logic val, input int maxc, output int cnt);
        cnt = 0;
        do begin
            @(negedge i_core_clk);
            cnt++;
        end while (obs[idx] !== val && cnt < maxc);
    endtask

    task automatic wait_ch(output int cnt);
        logic [1:0] old;
        old = chsel;
        cnt = 0;
        do begin
            @(negedge i_core_clk);
            cnt++;
        end while (chsel === old && cnt < 1000);
    endtask

    task automatic drive(input logic [3:0] c);
        @(posedge i_core_clk);
        cmd <= c;
    endtask

    task automatic idle(input int k);
        repeat (k) @(negedge i_core_clk);
    endtask

    task automatic done(input string s);
        $display("test %s ended, mismatches so far %0d", s, bad_count);
    endtask

    initial begin
        i_core_clk = 1'b0;
        forever #20 i_core_clk = ~i_core_clk;
    end

    always @(posedge i_core_clk) begin
        cyc <= cyc + 1;
        if (cyc == CEIL) begin
            bad_count++;
            final_report();
        end
    end

    initial begin
        n = $urandom(32'h0000_f28e);
        i_rst_n = 1'b0;
        cmd = 4'h0;
        cyc = 0;
        lag = 2'($urandom_range(3, 0));
        pv = 1'b1;
        scan_en = 1'b1;
        code_fit = 1'b1;
        ch = $urandom_range(3, 0);
        home = 2'(ch);
        member = 4'hf;
        rep_en = 4'hf;
        ku_en = 4'hf;
        hold_en = 4'hf;
        for (int i = 0; i < 4; i++) begin
            lim_l[i*10+:10] = 10'($urandom_range(600, 2));
            lim_r[i*10+:10] = 10'($urandom_range(600, 2));
            lim_p[i*10+:10] = 10'($urandom_range(600, 2));
            hold[i*7+:7] = 7'($urandom_range(100, 10));
        end
        lim_l[ch*10+:10] = 10'h001;
        lim_r[ch*10+:10] = 10'h001;
        lim_p[ch*10+:10] = 10'h001;
        hold[ch*7+:7] = 7'h05;
        idle(16);
        chk({amp, ant, locked, holding, tmo, chsel}, 0);
        @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        // Quiet scan hops every 80 ms, then locks on an open squelch
        wait_ch(n);
        for (int k = 0; k < 4; k++) begin
            prev = chsel;
            exp_q.push_back((prev + 1) % 4);
            wait_ch(n);
            chk(chsel, exp_q.pop_front());
            chk_near(n, 80 * MS, 2);
        end
        drive(4'b0100);
        wait_bit(4, 1'b1, 12, n);
        chk(locked, 1'b1);
        prev = chsel;
        idle(1000);
        chk(chsel, prev);
        drive(4'b0000);
        wait_ch(n);
        chk_near(n, 80 * MS, 12);
        @(posedge i_core_clk);
        scan_en <= 1'b0;
        idle(4);
        chk(chsel, ch);
        done("scan");
        // Local keying times out on the active channel limit of 1 s
        drive(4'b0001);
        wait_bit(0, 1'b1, 20, n);
        chk_near(n, 5 + lag, 1);
        chk(ant, 1'b1);
        wait_bit(1, 1'b1, 12000, n);
        chk_near(n, 1000 * MS, TOL);
        idle(3);
        chk({amp, ant}, 2'b00);
        drive(4'b0000);
        idle(10);
        chk(tmo, 3'b000);
        done("local_limit");
        // Releasing the remote restarts the local count
        drive(4'b0011);
        idle(3000);
        drive(4'b0001);
        wait_bit(1, 1'b1, 12000, n);
        chk_near(n, 1000 * MS, TOL);
        drive(4'b0000);
        idle(8);
        done("restart");
        // Repeat refused without code, then without channel repeat enable
        drive(4'b0100);
        idle(20);
        chk(amp, 1'b0);
        @(posedge i_core_clk);
        rep_en <= 4'h0;
        cmd <= 4'b1100;
        idle(20);
        chk(amp, 1'b0);
        @(posedge i_core_clk);
        rep_en <= 4'hf;
        wait_bit(0, 1'b1, 10, n);
        chk(amp, 1'b1);
        // Hold after repeat end, bridged by a new repeat, then expiry
        drive(4'b0000);
        idle(2000);
        chk({amp, holding}, 2'b11);
        drive(4'b1100);
        idle(10);
        chk({amp, holding}, 2'b10);
        drive(4'b0000);
        wait_bit(0, 1'b0, 8000, n);
        chk_near(n, 500 * MS, TOL);
        drive(4'b0001);
        idle(10);
        drive(4'b0000);
        wait_bit(0, 1'b0, 12, n);
        chk(holding, 1'b0);
        done("hold");
        // Timed-out repeat blocks repeats but not the remote
        drive(4'b1100);
        wait_bit(3, 1'b1, 12000, n);
        chk_near(n, 1000 * MS, TOL);
        idle(3);
        chk({amp, holding}, 2'b00);
        drive(4'b1110);
        wait_bit(0, 1'b1, 12, n);
        chk(amp, 1'b1);
        drive(4'b1100);
        idle(10);
        chk({amp, tmo[2]}, 2'b01);
        drive(4'b0000);
        idle(10);
        chk(tmo, 3'b000);
        done("repeat_lockout");
        // Disabled timers neither cut nor hold
        @(posedge i_core_clk);
        ku_en[ch] <= 1'b0;
        hold_en[ch] <= 1'b0;
        lim_l[ch*10+:10] <= 10'h000;
        drive(4'b1101);
        idle(100);
        chk({amp, tmo}, 4'b1000);
        drive(4'b0000);
        idle(10);
        chk({amp, holding}, 2'b00);
        done("disabled");
        // Shipped hold time applies without a personality
        @(posedge i_core_clk);
        pv <= 1'b0;
        drive(4'b1100);
        idle(20);
        drive(4'b0000);
        wait_bit(0, 1'b0, 32000, n);
        chk_near(n, 3000 * MS, TOL);
        done("defaults");
        final_report();
    end
endmodule // tb_top
